// File: flash_cmd_engine.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Opcode 05h reads status one, 35h status two, sampled on rising edges.
// - Status byte goes out on lane_one, falling edges, MSB first.
// - Status reads are accepted even while busy.
// - Status byte repeats until select rises.
// - Only status bits 7..2 and 14..8 are writable.
// - One-time lock bits never return to zero.
// - Non-volatile status write needs write_latch set by 06h first.
// - 50h before 01h makes a volatile write; write_latch stays zero.
// - Volatile writes cannot clear protect_lock_high or lock bits.
// - Status write counts only if select rises after 8 or 16 bits.
// - Eight-bit write clears complement, four_lane_enable, and protect_lock_high if non-volatile.
// - Non-volatile write runs a timed cycle with busy held high.
// - write_latch clears when the timed cycle ends.
// - Volatile write applies at once, busy stays low.
// - All status bits start at zero.
// - 03h plus 24-bit address, MSB first, on rising edges.
// - Read streams bytes, address advancing each byte, until select rises.
// - Plain read while busy is ignored.
// - 0Bh adds eight dummy clocks, input ignored during them.
// - 3Bh reads two bits per clock on lanes zero and one.
// - 6Bh reads four lanes, only while four_lane_enable is set.
// - Dual lanes: lane_zero even bits, lane_one odd bits.
// - Quad lanes: bits 7..4 then bits 3..0.
module flash_cmd_engine #(
    parameter int unsigned TW_NS = 5000000
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic [3:0]  lane_in,
    output logic      [3:0]  lane_out,
    output logic      [3:0]  lane_oe,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack
);

    // ========================================
    // Self-timed write length
    localparam int CLK_PERIOD_NS = flash_cmd_pkg::CLK_PERIOD_NS;
    localparam int TW_RAW = (TW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] TW_COUNT = (TW_RAW < 1) ? 32'h0000_0001 : 32'(TW_RAW);

    flash_cmd_pkg::state_t st;
    flash_cmd_pkg::state_t next_st;

    logic       busy;
    logic       cs_rise;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       op_done;
    logic [7:0] op_now;

    // ========================================
    // Status byte as seen by the host, busy kept live
    function automatic logic [7:0] status_byte(
        input flash_cmd_pkg::state_t s,
        input logic                  second
    );
        logic b;
        b = s.wip | s.ext_busy;
        if (second) begin
            status_byte = s.sr2 & flash_cmd_pkg::SR2_RD_MASK;
        end else begin
            status_byte = {s.sr1[7:2], s.write_latch, b};
        end
    endfunction

    // Merge written data into status; returns {sr2, sr1}
    function automatic logic [15:0] merge_status(
        input logic [7:0]  o1,
        input logic [7:0]  o2,
        input logic [15:0] w,
        input logic        short_wr,
        input logic        vol
    );
        logic [7:0] b1;
        logic [7:0] n1;
        logic [7:0] n2;
        b1 = short_wr ? w[7:0] : w[15:8];
        n1 = (o1 & ~flash_cmd_pkg::SR1_WR_MASK) | (b1 & flash_cmd_pkg::SR1_WR_MASK);
        if (short_wr) begin
            n2 = o2 & ~flash_cmd_pkg::SR2_SHORT_CLR;
        end else begin
            n2 = (o2 & ~flash_cmd_pkg::SR2_WR_MASK) | (w[7:0] & flash_cmd_pkg::SR2_WR_MASK);
        end
        n2 = n2 | (o2 & flash_cmd_pkg::SR2_OTP_MASK);
        if (vol) begin
            n2 = n2 | (o2 & flash_cmd_pkg::SR2_LOCK_HIGH);
        end
        merge_status = {n2, n1 & flash_cmd_pkg::SR1_WR_MASK};
    endfunction

    // ========================================
    // Edge events from the second synchroniser stage only
    assign busy      = st.wip | st.ext_busy;
    assign cs_rise   = st.sync2.cs_n & ~st.prev_cs_n;
    assign sclk_rise = st.sync2.sclk & ~st.prev_sclk & ~st.sync2.cs_n;
    assign sclk_fall = ~st.sync2.sclk & st.prev_sclk & ~st.sync2.cs_n;
    assign op_now    = {st.shreg[6:0], st.sync2.lanes[0]};
    assign op_done   = sclk_rise && (st.phase == flash_cmd_pkg::PH_OPCODE)
                       && (st.bitcnt == flash_cmd_pkg::OPCODE_LAST);

    // Outputs come straight from the state register
    assign lane_out = st.lane_out;
    assign lane_oe  = st.lane_oe;
    assign wb_dat_r = st.wb_dat;
    assign wb_ack   = st.wb_ack;

    // ========================================
    // Next-state logic
    always_comb begin
        logic [15:0] merged;
        logic [5:0]  cnt;
        merged = 16'h0000;
        cnt = 6'h00;
        next_st = st;
        next_st.sync1 = {cs_n, sclk, lane_in};
        next_st.sync2 = st.sync1;
        next_st.prev_cs_n = st.sync2.cs_n;
        next_st.prev_sclk = st.sync2.sclk;

        // Wishbone slave: one wait state, ack dropped after one cycle
        next_st.wb_ack = wb_cyc && wb_stb && !st.wb_ack;
        next_st.wb_dat = 32'h0000_0000;
        if (next_st.wb_ack && wb_we && wb_sel[0]) begin
            if (wb_adr == flash_cmd_pkg::REG_CONTROL) begin
                next_st.ext_busy = wb_dat_w[0];
            end else if (wb_adr[7:6] == flash_cmd_pkg::MEM_WINDOW && wb_adr[1:0] == 2'h0) begin
                next_st.mem[wb_adr[5:2]] = wb_dat_w[7:0];
            end
        end else if (next_st.wb_ack && !wb_we) begin
            if (wb_adr == flash_cmd_pkg::REG_STATUS) begin
                next_st.wb_dat = {15'h0000, st.wip, status_byte(st, 1'h1), status_byte(st, 1'h0)};
            end else if (wb_adr == flash_cmd_pkg::REG_CONTROL) begin
                next_st.wb_dat = {31'h0000_0000, st.ext_busy};
            end else if (wb_adr[7:6] == flash_cmd_pkg::MEM_WINDOW && wb_adr[1:0] == 2'h0) begin
                next_st.wb_dat = {24'h00_0000, st.mem[wb_adr[5:2]]};
            end
        end

        // Self-timed status write; results land only at the end
        if (st.wip) begin
            if (st.twcnt <= 32'h0000_0001) begin
                next_st.wip = 1'h0;
                next_st.sr1 = st.pend[7:0];
                next_st.sr2 = st.pend[15:8];
                next_st.write_latch = 1'h0;
            end else begin
                next_st.twcnt = st.twcnt - 32'h0000_0001;
            end
        end

        if (st.sync2.cs_n) begin
            // Deselected: float lanes, restart capture
            next_st.lane_oe = 4'h0;
            next_st.lane_out = 4'h0;
            next_st.phase = flash_cmd_pkg::PH_OPCODE;
            next_st.bitcnt = 6'h00;
            next_st.cmd = flash_cmd_pkg::OP_NONE;
            if (cs_rise) begin
                // One-byte commands act only when select closes them
                next_st.vol_armed = 1'h0;
                if (st.phase == flash_cmd_pkg::PH_IGNORE) begin
                    case (st.cmd)
                        flash_cmd_pkg::OP_WRITE_EN: begin
                            next_st.write_latch = 1'h1;
                        end
                        flash_cmd_pkg::OP_WRITE_DIS: begin
                            next_st.write_latch = 1'h0;
                        end
                        flash_cmd_pkg::OP_VOL_EN: begin
                            next_st.vol_armed = 1'h1;
                        end
                        default: begin
                        end
                    endcase
                end
                // Status write: any other bit count is discarded
                if (st.phase == flash_cmd_pkg::PH_SR_IN
                    && (st.bitcnt == flash_cmd_pkg::BYTE_BITS
                        || st.bitcnt == flash_cmd_pkg::WORD_BITS)) begin
                    merged = merge_status(st.sr1, st.sr2, st.wbuf,
                                          st.bitcnt == flash_cmd_pkg::BYTE_BITS,
                                          st.vol_write);
                    if (st.vol_write) begin
                        next_st.sr1 = merged[7:0];
                        next_st.sr2 = merged[15:8];
                    end else begin
                        next_st.pend = merged;
                        next_st.wip = 1'h1;
                        next_st.twcnt = TW_COUNT;
                    end
                end
            end
        end else if (sclk_rise) begin
            // Input bits are taken on rising edges
            cnt = st.bitcnt + 6'h01;
            case (st.phase)
                flash_cmd_pkg::PH_OPCODE: begin
                    next_st.shreg = op_now;
                    next_st.bitcnt = cnt;
                    if (op_done) begin
                        next_st.bitcnt = 6'h00;
                        next_st.cmd = op_now;
                        next_st.phase = flash_cmd_pkg::PH_IGNORE;
                        next_st.width = flash_cmd_pkg::W_ONE;
                        next_st.dummy = 1'h0;
                        if (op_now == flash_cmd_pkg::OP_READ_SR1
                            || op_now == flash_cmd_pkg::OP_READ_SR2) begin
                            next_st.sr_sel = (op_now == flash_cmd_pkg::OP_READ_SR2);
                            next_st.phase = flash_cmd_pkg::PH_SR_OUT;
                            next_st.obuf = status_byte(st, next_st.sr_sel);
                        end else if (busy) begin
                            // Nothing else may disturb a running cycle
                            next_st.cmd = flash_cmd_pkg::OP_NONE;
                        end else begin
                            case (op_now)
                                flash_cmd_pkg::OP_WRITE_SR: begin
                                    if (st.write_latch || st.vol_armed) begin
                                        next_st.phase = flash_cmd_pkg::PH_SR_IN;
                                        next_st.vol_write = st.vol_armed;
                                        next_st.wbuf = 16'h0000;
                                    end
                                end
                                flash_cmd_pkg::OP_READ: begin
                                    next_st.phase = flash_cmd_pkg::PH_ADDR;
                                end
                                flash_cmd_pkg::OP_FAST_READ: begin
                                    next_st.phase = flash_cmd_pkg::PH_ADDR;
                                    next_st.dummy = 1'h1;
                                end
                                flash_cmd_pkg::OP_DUAL_OUT: begin
                                    next_st.phase = flash_cmd_pkg::PH_ADDR;
                                    next_st.dummy = 1'h1;
                                    next_st.width = flash_cmd_pkg::W_TWO;
                                end
                                flash_cmd_pkg::OP_QUAD_OUT: begin
                                    if (st.sr2[flash_cmd_pkg::SR2_QE]) begin
                                        next_st.phase = flash_cmd_pkg::PH_ADDR;
                                        next_st.dummy = 1'h1;
                                        next_st.width = flash_cmd_pkg::W_FOUR;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                flash_cmd_pkg::PH_ADDR: begin
                    next_st.addr = {st.addr[22:0], st.sync2.lanes[0]};
                    next_st.bitcnt = cnt;
                    if (st.bitcnt == flash_cmd_pkg::ADDR_LAST) begin
                        next_st.bitcnt = 6'h00;
                        if (st.dummy) begin
                            next_st.phase = flash_cmd_pkg::PH_DUMMY;
                        end else begin
                            next_st.phase = flash_cmd_pkg::PH_DATA;
                            next_st.obuf = st.mem[next_st.addr[3:0]];
                        end
                    end
                end
                flash_cmd_pkg::PH_DUMMY: begin
                    // Lane inputs are not looked at here
                    next_st.bitcnt = cnt;
                    if (st.bitcnt == flash_cmd_pkg::DUMMY_LAST) begin
                        next_st.bitcnt = 6'h00;
                        next_st.phase = flash_cmd_pkg::PH_DATA;
                        next_st.obuf = st.mem[st.addr[3:0]];
                    end
                end
                flash_cmd_pkg::PH_SR_IN: begin
                    next_st.wbuf = {st.wbuf[14:0], st.sync2.lanes[0]};
                    if (st.bitcnt != flash_cmd_pkg::COUNT_MAX) begin
                        next_st.bitcnt = cnt;
                    end
                end
                default: begin
                end
            endcase
        end else if (sclk_fall) begin
            // Output bits change on falling edges; lanes open on the first one
            if (st.phase == flash_cmd_pkg::PH_DATA || st.phase == flash_cmd_pkg::PH_SR_OUT) begin
                case (st.width)
                    flash_cmd_pkg::W_FOUR: begin
                        next_st.lane_out = st.obuf[7:4];
                        next_st.lane_oe = 4'hF;
                    end
                    flash_cmd_pkg::W_TWO: begin
                        next_st.lane_out = {2'h0, st.obuf[7:6]};
                        next_st.lane_oe = 4'h3;
                    end
                    default: begin
                        next_st.lane_out = {2'h0, st.obuf[7], 1'h0};
                        next_st.lane_oe = 4'h2;
                    end
                endcase
                next_st.obuf = st.obuf << st.width;
                cnt = st.bitcnt + {3'h0, st.width};
                next_st.bitcnt = cnt;
                if (cnt == flash_cmd_pkg::BYTE_BITS) begin
                    next_st.bitcnt = 6'h00;
                    if (st.phase == flash_cmd_pkg::PH_SR_OUT) begin
                        next_st.obuf = status_byte(st, st.sr_sel);
                    end else begin
                        next_st.addr = st.addr + 24'h00_0001;
                        next_st.obuf = st.mem[next_st.addr[3:0]];
                    end
                end
            end
        end
    end

    // State register; status starts all zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= flash_cmd_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // Checks
    AST_STATUS_SHIFT: assert property (@(posedge clock) disable iff (!rst_n)
        sclk_fall && st.phase == flash_cmd_pkg::PH_SR_OUT
        |=> st.lane_out[1] == $past(st.obuf[7]) && st.lane_oe == 4'h2)
        else $error("status bit not driven on lane one");

    AST_BUSY_HELD: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(st.wip) |-> st.wip [*8])
        else $error("busy dropped early");

    AST_LATCH_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(st.wip) |-> !st.write_latch)
        else $error("write latch left set after timed write");

    AST_OTP_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
        (($past(st.sr2) & flash_cmd_pkg::SR2_OTP_MASK) & ~st.sr2) == 8'h00)
        else $error("lock bit returned to zero");

    AST_VOL_NO_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
        cs_rise && st.phase == flash_cmd_pkg::PH_SR_IN && st.vol_write
        |=> !st.wip ##1 !st.wip)
        else $error("volatile write raised busy");

    AST_BAD_LENGTH: assert property (@(posedge clock) disable iff (!rst_n)
        cs_rise && st.phase == flash_cmd_pkg::PH_SR_IN
        && st.bitcnt != flash_cmd_pkg::BYTE_BITS && st.bitcnt != flash_cmd_pkg::WORD_BITS
        |=> !st.wip && st.sr1 == $past(st.sr1) && st.sr2 == $past(st.sr2))
        else $error("status write of wrong length took effect");

    AST_READ_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
        op_done && busy && op_now == flash_cmd_pkg::OP_READ
        |=> st.phase == flash_cmd_pkg::PH_IGNORE)
        else $error("read accepted while busy");

    AST_QUAD_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        op_done && !busy && op_now == flash_cmd_pkg::OP_QUAD_OUT && !st.sr2[flash_cmd_pkg::SR2_QE]
        |=> st.phase == flash_cmd_pkg::PH_IGNORE)
        else $error("quad read accepted without enable");

    AST_ADDR_STEP: assert property (@(posedge clock) disable iff (!rst_n)
        sclk_fall && st.phase == flash_cmd_pkg::PH_DATA
        && (st.bitcnt + 6'(st.width)) == flash_cmd_pkg::BYTE_BITS
        |=> st.addr == $past(st.addr) + 24'h00_0001)
        else $error("address did not advance");

    AST_DUAL_LANES: assert property (@(posedge clock) disable iff (!rst_n)
        sclk_fall && st.phase == flash_cmd_pkg::PH_DATA && st.width == flash_cmd_pkg::W_TWO
        |=> st.lane_out[1:0] == $past(st.obuf[7:6]) && st.lane_oe == 4'h3)
        else $error("dual lane order wrong");

    AST_QUAD_LANES: assert property (@(posedge clock) disable iff (!rst_n)
        sclk_fall && st.phase == flash_cmd_pkg::PH_DATA && st.width == flash_cmd_pkg::W_FOUR
        |=> st.lane_out == $past(st.obuf[7:4]) && st.lane_oe == 4'hF)
        else $error("quad lane order wrong");

    AST_DESELECT_FLOAT: assert property (@(posedge clock) disable iff (!rst_n)
        st.sync2.cs_n |=> st.lane_oe == 4'h0 && st.phase == flash_cmd_pkg::PH_OPCODE)
        else $error("lanes driven while deselected");

endmodule

// File: flash_cmd_pkg.sv
package flash_cmd_pkg;

    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;

    // ========================================
    // Opcodes
    localparam logic [7:0] OP_NONE       = 8'h00;
    localparam logic [7:0] OP_WRITE_SR   = 8'h01;
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_WRITE_DIS  = 8'h04;
    localparam logic [7:0] OP_READ_SR1   = 8'h05;
    localparam logic [7:0] OP_WRITE_EN   = 8'h06;
    localparam logic [7:0] OP_FAST_READ  = 8'h0B;
    localparam logic [7:0] OP_READ_SR2   = 8'h35;
    localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
    localparam logic [7:0] OP_VOL_EN     = 8'h50;
    localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;

    // ========================================
    // Bit counts and lane widths
    localparam logic [5:0] OPCODE_LAST = 6'h07;
    localparam logic [5:0] ADDR_LAST   = 6'h17;
    localparam logic [5:0] DUMMY_LAST  = 6'h07;
    localparam logic [5:0] BYTE_BITS   = 6'h08;
    localparam logic [5:0] WORD_BITS   = 6'h10;
    localparam logic [5:0] COUNT_MAX   = 6'h3F;
    localparam logic [2:0] W_ONE       = 3'h1;
    localparam logic [2:0] W_TWO       = 3'h2;
    localparam logic [2:0] W_FOUR      = 3'h4;

    // ========================================
    // Status layout (sr2 bit n is status bit n+8)
    localparam logic [7:0] SR1_WR_MASK   = 8'hFC;
    localparam logic [7:0] SR2_WR_MASK   = 8'h7F;
    localparam logic [7:0] SR2_RD_MASK   = 8'h7F;
    localparam logic [7:0] SR2_OTP_MASK  = 8'h38;
    localparam logic [7:0] SR2_SHORT_CLR = 8'h43;
    localparam logic [7:0] SR2_LOCK_HIGH = 8'h01;
    localparam int         SR2_QE        = 1;

    // ========================================
    // Wishbone map
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h04;
    localparam logic [1:0] MEM_WINDOW  = 2'h1;

    // ========================================
    // Types
    typedef enum logic [2:0] {
        PH_OPCODE = 3'h0,
        PH_ADDR   = 3'h1,
        PH_DUMMY  = 3'h3,
        PH_DATA   = 3'h2,
        PH_SR_OUT = 3'h6,
        PH_SR_IN  = 3'h7,
        PH_IGNORE = 3'h5
    } phase_t;

    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] lanes;
    } pins_t;

    typedef struct packed {
        pins_t           sync1;
        pins_t           sync2;
        logic            prev_cs_n;
        logic            prev_sclk;
        phase_t          phase;
        logic [7:0]      cmd;
        logic [7:0]      shreg;
        logic [5:0]      bitcnt;
        logic [23:0]     addr;
        logic [2:0]      width;
        logic            dummy;
        logic            sr_sel;
        logic            vol_write;
        logic            vol_armed;
        logic            write_latch;
        logic            wip;
        logic            ext_busy;
        logic [7:0]      obuf;
        logic [15:0]     wbuf;
        logic [15:0]     pend;
        logic [7:0]      sr1;
        logic [7:0]      sr2;
        logic [31:0]     twcnt;
        logic [3:0]      lane_out;
        logic [3:0]      lane_oe;
        logic            wb_ack;
        logic [31:0]     wb_dat;
        logic [15:0][7:0] mem;
    } state_t;

    // Select idles high, so its synchroniser and edge history start high too;
    // an all-zero start would fake a select edge just after reset
    function automatic state_t reset_state();
        reset_state = '0;
        reset_state.sync1.cs_n = 1'b1;
        reset_state.sync2.cs_n = 1'b1;
        reset_state.prev_cs_n = 1'b1;
    endfunction

    localparam state_t STATE_RESET = reset_state();

endpackage

// File: spi_host.sv
`timescale 1ns/100ps
// ========================================
// Host model: mode 0 at a 48 ns link period, clock still between frames
module spi_host (
    input  wire logic [3:0] lanes,
    input  wire logic       clock,
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      drive,
    output logic [3:0]      host_oe
);
    // Host holds lane zero and the two side lanes, never the serial output lane
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        drive = 4'h0;
        host_oe = 4'hD;
    end
    // Shift tx out MSB first, gather w lanes at each rising edge; the link
    // edges sit off the system clock grid, so no edge meets a clock edge
    task automatic frame(input int nb, input logic [63:0] tx, input int w,
                         input int rel, output logic [63:0] rx);
        rx = '0;
        @(posedge clock);
        #1.3;
        cs_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            // Last rel clocks: lanes let go before the first data falling edge
            host_oe = (i < rel) ? 4'h0 : 4'hD;
            // Idle lanes toggle so a stale level can never pass as data
            drive = {{3{~tx[i]}}, tx[i]};
            #24;
            sclk = 1'b1;
            rx = (rx << w) | (w == 1 ? 64'(lanes[1]) : w == 2 ? 64'(lanes[1:0]) : 64'(lanes));
            #24;
            sclk = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        // Two link periods deselected before the lanes are taken back
        #96;
        host_oe = 4'hD;
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        cs_n, sclk, wb_ack;
    logic [3:0]  drive, lane_out, lane_oe, host_oe;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = '0, wb_dat_r, r;
    logic [63:0] rx;
    int          fails = 0, checked = 0;
    // A lane that neither side drives shows the inverse of the host pattern
    wire  [3:0]  lanes = (lane_oe & lane_out) | (~lane_oe & host_oe & drive)
                         | (~lane_oe & ~host_oe & ~drive);
    // ========================================
    // Clock, host, device
    always #2.5 clock = ~clock;
    spi_host host (.lanes(lanes), .clock(clock), .cs_n(cs_n), .sclk(sclk), .drive(drive),
        .host_oe(host_oe));
    // Host and device must never drive one lane together
    always @(posedge clock) begin
        if ((lane_oe & host_oe) != 4'h0) begin
            fails++;
            $display("wrong value at %0t: host and device drive one lane", $time);
        end
    end
    flash_cmd_engine #(.TW_NS(200)) dut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
        .sclk(sclk), .lane_in(lanes), .lane_out(lane_out), .lane_oe(lane_oe), .wb_cyc(cyc),
        .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(4'hF), .wb_dat_w(dat),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
    function automatic logic [7:0] m(input logic [3:0] n);
        return {n, ~n};
    endfunction
    // One classic cycle; the watchdog bounds the wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clock); while (wb_ack !== 1'b1);
        r = wb_dat_r;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_reset;
        wb(0, 8'h00, 0); chk(r, 0);
        wb(0, 8'h20, 0); chk(r, 0);
        for (int n = 0; n < 16; n++) wb(1, 8'(8'h40 + 4 * n), 32'(m(4'(n))));
        $display("reset test done");
    endtask
    task automatic t_reads;
        host.frame(48, 64'h0000_03FF_FFFF_5555, 1, 0, rx);
        chk(rx[15:0], {m(15), m(0)});
        host.frame(48, 64'h0000_0B00_0005_0055, 1, 0, rx);
        chk(rx[7:0], m(5));
        host.frame(48, 64'h0000_3B00_0007_0055, 2, 16, rx);
        chk(rx[15:0], {m(7), m(8)});
        host.frame(44, 64'h0000_06B0_0000_9005, 4, 12, rx);
        chk(rx[15:0], 16'h1E1E);
        $display("read test done");
    endtask
    task automatic t_volatile;
        host.frame(8, 64'h50, 1, 0, rx);
        host.frame(24, 64'h0001_0002, 1, 0, rx);
        wb(0, 8'h00, 0); chk(r, 32'h0000_0200);
        host.frame(24, 64'h0035_5555, 1, 0, rx); chk(rx[15:0], 16'h0202);
        host.frame(44, 64'h0000_06B0_0000_9005, 4, 12, rx);
        chk(rx[15:0], {m(9), m(10)});
        $display("volatile test done");
    endtask
    task automatic t_nonvolatile;
        host.frame(8, 64'h06, 1, 0, rx);
        wb(0, 8'h00, 0); chk(r, 32'h0000_0202);
        host.frame(20, 64'h0000_1FFF, 1, 0, rx);
        wb(0, 8'h00, 0); chk(r, 32'h0000_0202);
        host.frame(16, 64'h01FF, 1, 0, rx);
        wb(0, 8'h00, 0); chk(r, 32'h0001_0203);
        repeat (60) @(posedge clock);
        wb(0, 8'h00, 0); chk(r, 32'h0000_00FC);
        $display("nonvolatile test done");
    endtask
    task automatic t_busy;
        wb(1, 8'h04, 1);
        wb(0, 8'h04, 0); chk(r, 32'h0000_0001);
        host.frame(24, 64'h0005_5555, 1, 0, rx); chk(rx[15:0], 16'hFDFD);
        host.frame(48, 64'h0000_0300_0000_5555, 1, 0, rx); chk(rx[15:0], 16'h5555);
        wb(1, 8'h04, 0);
        host.frame(8, 64'h06, 1, 0, rx);
        wb(0, 8'h00, 0); chk(r, 32'h0000_00FE);
        host.frame(8, 64'h04, 1, 0, rx);
        wb(0, 8'h00, 0); chk(r, 32'h0000_00FC);
        $display("busy test done");
    endtask
    task automatic finish_test;
        $display("%0d checks, %0d mismatches", checked, fails);
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog sized well above the roughly 23 us the tests need
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (5) @(posedge clock);
        t_reset(); t_reads(); t_volatile(); t_nonvolatile(); t_busy();
        finish_test();
    end
endmodule
